// ==== hdl/lmt_lane_mapper.sv ====
// Lane mapper, sync header select and serializer test-pattern source
`timescale 1ns/10ps
module lmt_lane_mapper (
    // AHB-Lite slave
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Converter samples, one frame per clock
    input wire logic [7:0][lmt_pkg::LMT_SMP_W-1:0] conv_a_sample,
    input wire logic [7:0][lmt_pkg::LMT_SMP_W-1:0] conv_b_sample,
    // Down-converter words
    input wire logic [7:0][lmt_pkg::LMT_DDC_W-1:0] ddc_a_i,
    input wire logic [7:0][lmt_pkg::LMT_DDC_W-1:0] ddc_a_q,
    input wire logic [7:0] first_overrange_flag,
    input wire logic [7:0] second_overrange_flag,
    input wire logic [lmt_pkg::LMT_DDC_W-1:0] ddc_b_i,
    input wire logic [lmt_pkg::LMT_DDC_W-1:0] ddc_b_q,
    input wire logic ovr_b_i,
    input wire logic ovr_b_q,
    // Shutdown pin
    input wire logic full_shutdown_input,
    // Lane outputs
    output logic [7:0][lmt_pkg::LMT_LANE_W-1:0] bank_a_data,
    output logic [7:0][lmt_pkg::LMT_LANE_W-1:0] bank_b_data,
    output logic [15:0] lane_active,
    output logic serdes_drive_en,
    output logic sync_hdr_fec,
    output logic first_channel_power_down,
    output logic second_channel_power_down
);
    import lmt_pkg::*;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [15:0] lmt_lane_mask(input logic [7:0] mode);
        logic [15:0] m;
        m = 16'h0000;
        case (mode)
            LMT_MODE_D8_16L: m = LMT_LANES_ALL;
            LMT_MODE_12B_SC, LMT_MODE_12B_DC: m = LMT_LANES_SIX;
            LMT_MODE_8B_SC, LMT_MODE_8B_DC, LMT_MODE_D4_DC: m = LMT_LANES_FOUR;
            LMT_MODE_D8_SC, LMT_MODE_D8_DC, LMT_MODE_D16_DC: m = LMT_LANES_TWO;
            default: m = 16'h0000;
        endcase
        return m;
    endfunction : lmt_lane_mask

    function automatic logic lmt_is_dual(input logic [7:0] mode);
        return (mode == LMT_MODE_12B_DC) || (mode == LMT_MODE_8B_DC) ||
            (mode == LMT_MODE_D4_DC) || (mode == LMT_MODE_D8_DC) ||
            (mode == LMT_MODE_D16_DC);
    endfunction : lmt_is_dual

    // Thirty-two serial bits, first bit in the MSB
    function automatic logic [62:0] lmt_prbs32(input logic [30:0] st, input logic [3:0] sel);
        logic [30:0] s;
        logic [31:0] w;
        logic b;
        int ta;
        int tb;
        s = st;
        w = 32'h00000000;
        ta = 6;
        tb = 7;
        case (sel)
            LMT_PAT_PRBS9:
            begin
                ta = 5;
                tb = 9;
            end
            LMT_PAT_PRBS15:
            begin
                ta = 14;
                tb = 15;
            end
            LMT_PAT_PRBS23:
            begin
                ta = 18;
                tb = 23;
            end
            LMT_PAT_PRBS31:
            begin
                ta = 28;
                tb = 31;
            end
            default:
            begin
                ta = 6;
                tb = 7;
            end
        endcase
        for (int i = 0; i < 32; i++)
        begin
            b = s[ta-1] ^ s[tb-1];
            s = {s[29:0], b};
            w = {w[30:0], b};
        end
        return {s, w};
    endfunction : lmt_prbs32

    function automatic logic [15:0] lmt_word(input logic [LMT_DDC_W-1:0] v, input logic o);
        return {v, o};
    endfunction : lmt_word

    // ---------------------------------------------------------------
    // AHB-Lite register slave
    // ---------------------------------------------------------------
    logic [LMT_CTRL_W-1:0] ctrl_r;
    logic wr_pend_r;
    logic [11:0] addr_r;
    logic [7:0] mode;
    logic [3:0] pat;
    logic drive_en_r;
    logic pd_meta_r;
    logic pd_sync_r;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign mode = ctrl_r[LMT_F_MODE_HI:LMT_F_MODE_LO];
    assign pat = ctrl_r[LMT_F_PAT_HI:LMT_F_PAT_LO];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            addr_r <= 12'h000;
        end
        else if (hready)
        begin
            wr_pend_r <= hsel && htrans[1] && hwrite;
            addr_r <= haddr[11:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_r <= LMT_CTRL_RESET;
        else if (wr_pend_r && addr_r == LMT_ADDR_CTRL)
            ctrl_r <= hwdata[LMT_CTRL_W-1:0];
    end

    always_comb
    begin
        hrdata = 32'h00000000;
        if (addr_r == LMT_ADDR_CTRL)
            hrdata[LMT_CTRL_W-1:0] = ctrl_r;
        else if (addr_r == LMT_ADDR_STATUS)
        begin
            hrdata[LMT_S_LANES_LO +: 16] = lmt_lane_mask(mode);
            hrdata[LMT_S_DRIVE_EN] = drive_en_r;
            hrdata[LMT_S_MODE_OK] = |lmt_lane_mask(mode);
        end
    end

    assign sync_hdr_fec = ctrl_r[LMT_F_SYNC_FEC];
    assign first_channel_power_down = ctrl_r[LMT_F_PD_FIRST];
    assign second_channel_power_down = ctrl_r[LMT_F_PD_SECOND];

    // ---------------------------------------------------------------
    // Shutdown pin and driver enable
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pd_meta_r <= 1'b1;
            pd_sync_r <= 1'b1;
            drive_en_r <= 1'b0;
        end
        else
        begin
            pd_meta_r <= full_shutdown_input;
            pd_sync_r <= pd_meta_r;
            drive_en_r <= !pd_sync_r && !ctrl_r[LMT_F_CFG_PD];
        end
    end

    assign serdes_drive_en = drive_en_r;
    assign lane_active = drive_en_r ? lmt_lane_mask(mode) : 16'h0000;

    // ---------------------------------------------------------------
    // Channel power-down and binding
    // ---------------------------------------------------------------
    logic [7:0][LMT_SMP_W-1:0] raw_a;
    logic [7:0][LMT_SMP_W-1:0] raw_b;
    logic [7:0][LMT_SMP_W-1:0] ch_a;
    logic [7:0][LMT_SMP_W-1:0] ch_b;
    logic [15:0] w_ai;
    logic [15:0] w_aq;
    logic [15:0] w_bi;
    logic [15:0] w_bq;
    logic dual;
    logic bind_first;
    logic bind_second;

    assign dual = lmt_is_dual(mode);
    assign bind_first = dual && ctrl_r[LMT_F_BIND_FIRST];
    assign bind_second = dual && !bind_first && ctrl_r[LMT_F_BIND_SECOND];
    assign raw_a = first_channel_power_down ? '0 : conv_a_sample;
    assign raw_b = second_channel_power_down ? '0 : conv_b_sample;
    assign ch_a = bind_second ? raw_b : raw_a;
    assign ch_b = bind_first ? raw_a : raw_b;

    always_comb
    begin
        w_ai = lmt_word(ddc_a_i[0], first_overrange_flag[0]);
        w_aq = lmt_word(ddc_a_q[0], second_overrange_flag[0]);
        w_bi = lmt_word(ddc_b_i, ovr_b_i);
        w_bq = lmt_word(ddc_b_q, ovr_b_q);
        if (bind_first)
        begin
            w_bi = w_ai;
            w_bq = w_aq;
        end
        else if (bind_second)
        begin
            w_ai = w_bi;
            w_aq = w_bq;
        end
    end

    // ---------------------------------------------------------------
    // PRBS generators, one per lane
    // ---------------------------------------------------------------
    logic prbs_on;
    logic [30:0] prbs_st_r [LMT_LANES];
    logic [30:0] prbs_st_nxt [LMT_LANES];
    logic [31:0] prbs_word [LMT_LANES];

    assign prbs_on = (pat >= LMT_PAT_PRBS7) && (pat <= LMT_PAT_PRBS31);

    for (genvar g = 0; g < LMT_LANES; g++)
    begin : g_prbs
        localparam logic [30:0] SEED = 31'(g + 1);
        assign {prbs_st_nxt[g], prbs_word[g]} = lmt_prbs32(prbs_st_r[g], pat);
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
                prbs_st_r[g] <= SEED;
            else if (prbs_on && drive_en_r)
                prbs_st_r[g] <= prbs_st_nxt[g];
            else
                prbs_st_r[g] <= SEED;
        end
    end

    // ---------------------------------------------------------------
    // Lane mapping
    // ---------------------------------------------------------------
    logic [7:0][LMT_LANE_W-1:0] map_a;
    logic [7:0][LMT_LANE_W-1:0] map_b;
    logic [7:0][LMT_LANE_W-1:0] a_nxt;
    logic [7:0][LMT_LANE_W-1:0] b_nxt;
    logic [47:0] pk_a;
    logic [47:0] pk_b;
    logic [15:0] mask;

    always_comb
    begin
        map_a = '0;
        map_b = '0;
        pk_a = 48'h000000000000;
        pk_b = 48'h000000000000;
        case (mode)
            LMT_MODE_12B_SC:
            begin
                pk_a = {ch_a[0], ch_a[2], ch_a[4], ch_a[6]};
                pk_b = {ch_a[1], ch_a[3], ch_a[5], ch_a[7]};
            end
            LMT_MODE_12B_DC:
            begin
                pk_a = {ch_a[0], ch_a[1], ch_a[2], ch_a[3]};
                pk_b = {ch_b[0], ch_b[1], ch_b[2], ch_b[3]};
            end
            LMT_MODE_8B_SC:
            begin
                map_a[0] = {ch_a[0][11:4], 24'h000000};
                map_a[1] = {ch_a[2][11:4], 24'h000000};
                map_b[0] = {ch_a[1][11:4], 24'h000000};
                map_b[1] = {ch_a[3][11:4], 24'h000000};
            end
            LMT_MODE_8B_DC:
            begin
                map_a[0] = {ch_a[0][11:4], 24'h000000};
                map_a[1] = {ch_a[1][11:4], 24'h000000};
                map_b[0] = {ch_b[0][11:4], 24'h000000};
                map_b[1] = {ch_b[1][11:4], 24'h000000};
            end
            LMT_MODE_D8_16L:
            begin
                for (int k = 0; k < LMT_BANK_LANES; k++)
                begin
                    map_a[k] = {lmt_word(ddc_a_i[k], first_overrange_flag[k]), 16'h0000};
                    map_b[k] = {lmt_word(ddc_a_q[k], second_overrange_flag[k]), 16'h0000};
                end
            end
            LMT_MODE_D4_DC:
            begin
                map_a[0] = {w_ai, 16'h0000};
                map_a[1] = {w_aq, 16'h0000};
                map_b[0] = {w_bi, 16'h0000};
                map_b[1] = {w_bq, 16'h0000};
            end
            LMT_MODE_D8_SC:
            begin
                map_a[0] = {lmt_word(ddc_a_i[0], first_overrange_flag[0]), 16'h0000};
                map_b[0] = {lmt_word(ddc_a_q[0], second_overrange_flag[0]), 16'h0000};
            end
            LMT_MODE_D8_DC, LMT_MODE_D16_DC:
            begin
                map_a[0] = {w_ai, w_aq};
                map_b[0] = {w_bi, w_bq};
            end
            default:
            begin
                map_a = '0;
                map_b = '0;
            end
        endcase
        if (mode == LMT_MODE_12B_SC || mode == LMT_MODE_12B_DC)
        begin
            map_a[0] = {pk_a[47:32], 16'h0000};
            map_a[1] = {pk_a[31:16], 16'h0000};
            map_a[2] = {pk_a[15:0], 16'h0000};
            map_b[0] = {pk_b[47:32], 16'h0000};
            map_b[1] = {pk_b[31:16], 16'h0000};
            map_b[2] = {pk_b[15:0], 16'h0000};
        end
    end

    // Test patterns replace the mapped data on the mode's own lanes
    always_comb
    begin
        mask = lmt_lane_mask(mode);
        a_nxt = '0;
        b_nxt = '0;
        for (int k = 0; k < LMT_BANK_LANES; k++)
        begin
            if (pat == LMT_PAT_CLOCK)
            begin
                a_nxt[k] = LMT_CLK_WORD;
                b_nxt[k] = LMT_CLK_WORD;
            end
            else if (prbs_on)
            begin
                a_nxt[k] = prbs_word[k];
                b_nxt[k] = prbs_word[k+LMT_BANK_LANES];
            end
            else
            begin
                a_nxt[k] = map_a[k];
                b_nxt[k] = map_b[k];
            end
            if (!mask[k] || !drive_en_r)
                a_nxt[k] = 32'h00000000;
            if (!mask[k+LMT_BANK_LANES] || !drive_en_r)
                b_nxt[k] = 32'h00000000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bank_a_data <= '0;
            bank_b_data <= '0;
        end
        else
        begin
            bank_a_data <= a_nxt;
            bank_b_data <= b_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    logic map_on;
    assign map_on = drive_en_r && pat == LMT_PAT_OFF;

    AST_MODE32: assert property ((map_on && mode == LMT_MODE_12B_SC) |=>
        bank_b_data[0][31:16] == {$past(raw_a[1]), $past(raw_a[3][11:8])})
        else $error("mode 32 odd samples misplaced");
    AST_MODE33: assert property ((map_on && mode == LMT_MODE_12B_DC && !bind_first
        && !bind_second) |=> bank_b_data[2][31:16] ==
        {$past(raw_b[2][3:0]), $past(raw_b[3])})
        else $error("mode 33 channel B packing wrong");
    AST_MODE34: assert property ((map_on && mode == LMT_MODE_8B_SC) |=>
        bank_a_data[1][31:24] == $past(raw_a[2][11:4]))
        else $error("mode 34 octet wrong");
    AST_MODE35: assert property ((map_on && mode == LMT_MODE_8B_DC && !bind_first
        && !bind_second) |=> bank_b_data[1][31:24] == $past(raw_b[1][11:4]))
        else $error("mode 35 octet wrong");
    AST_MODE27: assert property ((map_on && mode == LMT_MODE_D8_16L) |=>
        bank_a_data[7][31:16] == {$past(ddc_a_i[7]), $past(first_overrange_flag[7])})
        else $error("mode 27 lane 7 wrong");
    AST_MODE37: assert property ((map_on && mode == LMT_MODE_D4_DC && !bind_second) |=>
        bank_a_data[1][31:16] == {$past(ddc_a_q[0]), $past(second_overrange_flag[0])})
        else $error("mode 37 quadrature word wrong");
    AST_MODE38: assert property ((map_on && mode == LMT_MODE_D8_SC) |=>
        bank_b_data[0][31:16] == {$past(ddc_a_q[0]), $past(second_overrange_flag[0])})
        else $error("mode 38 quadrature lane wrong");
    AST_MODE39: assert property ((map_on && (mode == LMT_MODE_D8_DC ||
        mode == LMT_MODE_D16_DC) && !bind_first) |=> bank_b_data[0] ==
        {$past(ddc_b_i), $past(ovr_b_i), $past(ddc_b_q), $past(ovr_b_q)})
        else $error("two-lane dual word order wrong");
    AST_BIND: assert property ((map_on && mode == LMT_MODE_12B_DC && bind_first)
        |=> bank_b_data[0] == bank_a_data[0])
        else $error("bound channel not on both banks");
    AST_SHUTDOWN: assert property ($rose(pd_sync_r) |=> !serdes_drive_en
        ##1 (bank_a_data == '0 && bank_b_data == '0))
        else $error("drivers not disabled on shutdown");
    AST_LANES: assert property ((drive_en_r && pat != LMT_PAT_OFF && !mask[2]) |=>
        bank_a_data[2] == '0)
        else $error("lane count changed by test mode");
    AST_CLOCK: assert property ((drive_en_r && pat == LMT_PAT_CLOCK && mode == LMT_MODE_8B_SC)
        |=> bank_a_data[0] == LMT_CLK_WORD && bank_b_data[1] == LMT_CLK_WORD)
        else $error("clock pattern wrong");
    AST_PRBS_LIVE: assert property (prbs_st_r[0] != '0 && prbs_st_r[15] != '0)
        else $error("generator locked at zero");
    AST_PRBS_PHASE: assert property (prbs_st_r[0] != prbs_st_r[1])
        else $error("lanes share a phase");

    COV_BIND: cover property (map_on && bind_first ##1 map_on);
    COV_PRBS: cover property ((prbs_on && drive_en_r) [*4]);
    COV_SHUT: cover property ($rose(pd_sync_r));
    COV_M27: cover property (map_on && mode == LMT_MODE_D8_16L);
endmodule : lmt_lane_mapper

// ==== hdl/lmt_pkg.sv ====
// Constants for the lane mapper and serializer test-pattern source
package lmt_pkg;
    // ---------------------------------------------------------------
    // Widths
    // ---------------------------------------------------------------
    localparam int LMT_SMP_W = 12;
    localparam int LMT_DDC_W = 15;
    localparam int LMT_LANE_W = 32;
    localparam int LMT_BANK_LANES = 8;
    localparam int LMT_LANES = 16;
    localparam int LMT_PRBS_W = 31;
    localparam int LMT_CTRL_W = 18;
    localparam int LMT_SYNC_STAGES = 2;
    // ---------------------------------------------------------------
    // Register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [11:0] LMT_ADDR_CTRL = 12'h000;
    localparam logic [11:0] LMT_ADDR_STATUS = 12'h004;
    localparam logic [LMT_CTRL_W-1:0] LMT_CTRL_RESET = 18'h00020;
    // Control field positions
    localparam int LMT_F_MODE_LO = 0;
    localparam int LMT_F_MODE_HI = 7;
    localparam int LMT_F_PAT_LO = 8;
    localparam int LMT_F_PAT_HI = 11;
    localparam int LMT_F_SYNC_FEC = 12;
    localparam int LMT_F_BIND_FIRST = 13;
    localparam int LMT_F_BIND_SECOND = 14;
    localparam int LMT_F_PD_FIRST = 15;
    localparam int LMT_F_PD_SECOND = 16;
    localparam int LMT_F_CFG_PD = 17;
    // Status field positions
    localparam int LMT_S_LANES_LO = 0;
    localparam int LMT_S_DRIVE_EN = 16;
    localparam int LMT_S_MODE_OK = 17;
    // ---------------------------------------------------------------
    // Lane modes
    // ---------------------------------------------------------------
    localparam logic [7:0] LMT_MODE_D8_16L = 8'h1b;
    localparam logic [7:0] LMT_MODE_12B_SC = 8'h20;
    localparam logic [7:0] LMT_MODE_12B_DC = 8'h21;
    localparam logic [7:0] LMT_MODE_8B_SC = 8'h22;
    localparam logic [7:0] LMT_MODE_8B_DC = 8'h23;
    localparam logic [7:0] LMT_MODE_D4_DC = 8'h25;
    localparam logic [7:0] LMT_MODE_D8_SC = 8'h26;
    localparam logic [7:0] LMT_MODE_D8_DC = 8'h27;
    localparam logic [7:0] LMT_MODE_D16_DC = 8'h38;
    // Active lanes, bank A in the low byte, bank B in the high byte
    localparam logic [15:0] LMT_LANES_ALL = 16'hffff;
    localparam logic [15:0] LMT_LANES_SIX = 16'h0707;
    localparam logic [15:0] LMT_LANES_FOUR = 16'h0303;
    localparam logic [15:0] LMT_LANES_TWO = 16'h0101;
    // ---------------------------------------------------------------
    // Test patterns
    // ---------------------------------------------------------------
    localparam logic [3:0] LMT_PAT_OFF = 4'h0;
    localparam logic [3:0] LMT_PAT_PRBS7 = 4'h1;
    localparam logic [3:0] LMT_PAT_PRBS9 = 4'h2;
    localparam logic [3:0] LMT_PAT_PRBS15 = 4'h3;
    localparam logic [3:0] LMT_PAT_PRBS23 = 4'h4;
    localparam logic [3:0] LMT_PAT_PRBS31 = 4'h5;
    localparam logic [3:0] LMT_PAT_CLOCK = 4'h6;
    localparam logic [31:0] LMT_CLK_WORD = 32'hff00ff00;
endpackage : lmt_pkg

// ==== tb/lmt_rx_model.sv ====
// Receiver-side model that self-synchronises to PRBS lanes
`timescale 1ns/10ps
module lmt_rx_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Observed lanes and control
    input wire logic [31:0] lane_x,
    input wire logic [31:0] lane_y,
    input wire logic drive_en,
    input wire logic check_en,
    input wire logic [4:0] tap_a,
    input wire logic [4:0] tap_b,
    // Results
    output logic [15:0] err_cnt,
    output logic [15:0] chk_cnt
);
    logic [31:0] prev_r;
    logic have_r;
    logic [63:0] s;
    logic bad;
    always_comb
    begin
        s = {prev_r, lane_x};
        bad = (lane_x == lane_y);
        for (int n = 32; n < 64; n++)
        begin
            bad |= s[63-n] != (s[63-n+tap_a] ^ s[63-n+tap_b]);
        end
    end
    // Words are discarded until the link has been up for a full word
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prev_r <= '0;
            have_r <= 1'b0;
            err_cnt <= '0;
            chk_cnt <= '0;
        end
        else
        begin
            prev_r <= lane_x;
            have_r <= check_en && drive_en;
            if (have_r && check_en && drive_en)
            begin
                chk_cnt <= chk_cnt + 16'h1;
                err_cnt <= err_cnt + {15'h0, bad};
            end
        end
    end
endmodule : lmt_rx_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the lane mapper
`timescale 1ns/10ps
module tb_top;
    import lmt_pkg::*;
    localparam int TA [5] = '{6, 5, 14, 18, 28};
    localparam int TB [5] = '{7, 9, 15, 23, 31};
    logic hclk, hresetn, hsel, hwrite, hrdy, hresp, pin, drv, fec, pd1, pd2, chk_en, obi, obq;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [7:0][LMT_SMP_W-1:0] sa, sb;
    logic [7:0][LMT_DDC_W-1:0] ai, aq;
    logic [7:0] o1, o2;
    logic [LMT_DDC_W-1:0] bi, bq;
    logic [7:0][31:0] da, db;
    logic [15:0] act, errs, chks;
    logic [4:0] ta, tb;
    int fail_count = 0;
    int compares = 0;
    lmt_lane_mapper lmt_lane_mapper_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .conv_a_sample(sa),
        .conv_b_sample(sb), .ddc_a_i(ai), .ddc_a_q(aq), .first_overrange_flag(o1),
        .second_overrange_flag(o2), .ddc_b_i(bi), .ddc_b_q(bq), .ovr_b_i(obi), .ovr_b_q(obq),
        .full_shutdown_input(pin), .bank_a_data(da), .bank_b_data(db), .lane_active(act),
        .serdes_drive_en(drv), .sync_hdr_fec(fec), .first_channel_power_down(pd1),
        .second_channel_power_down(pd2));
    lmt_rx_model lmt_rx_model_inst (.hclk(hclk), .hresetn(hresetn), .lane_x(da[0]),
        .lane_y(da[1]), .drive_en(drv), .check_en(chk_en), .tap_a(ta), .tap_b(tb),
        .err_cnt(errs), .chk_cnt(chks));
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task summarize;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge hclk); while (hrdy !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hrdy !== 1'b1);
        q = hrdata;
    endtask : bus
    task cfg(input logic [31:0] v);
        bus(1'b1, 32'(LMT_ADDR_CTRL), v);
        repeat (2) @(posedge hclk);
        #1;
    endtask : cfg
    task t_regs;
        bus(1'b0, 32'(LMT_ADDR_CTRL), 32'h0);
        chk("ctrl", 32'(LMT_CTRL_RESET), q);
        chk("hresp", 32'h0, hresp);
        bus(1'b1, 32'h10, 32'h3);
        bus(1'b0, 32'h10, 32'h0);
        chk("unmapped", 32'h0, q);
        bus(1'b0, 32'(LMT_ADDR_STATUS), 32'h0);
        chk("status", {14'h0, 2'b11, LMT_LANES_SIX}, q);
    endtask : t_regs
    task t_pack12;
        cfg(32'h20);
        chk("m32 a1", {sa[2][7:0], sa[4][11:4]}, da[1][31:16]);
        chk("m32 b2", {sa[5][3:0], sa[7]}, db[2][31:16]);
        cfg(32'h21);
        chk("m33 a2", {sa[2][3:0], sa[3]}, da[2][31:16]);
        chk("m33 b0", {sb[0], sb[1][11:8]}, db[0][31:16]);
        cfg(32'h12021);
        chk("bind b0", {sa[0], sa[1][11:8]}, db[0][31:16]);
        chk("pd2", 32'h1, pd2);
        cfg(32'hc021);
        chk("bind a0", {sb[0], sb[1][11:8]}, da[0][31:16]);
        chk("pd1", 32'h1, pd1);
        cfg(32'h4020);
        chk("m32 b0", {sa[1], sa[3][11:8]}, db[0][31:16]);
    endtask : t_pack12
    task t_pack8;
        cfg(32'h22);
        chk("m34 a1", sa[2][11:4], da[1][31:24]);
        chk("m34 b0", sa[1][11:4], db[0][31:24]);
        cfg(32'h23);
        chk("m35 a1", sa[1][11:4], da[1][31:24]);
        chk("m35 b1", sb[1][11:4], db[1][31:24]);
    endtask : t_pack8
    task t_words;
        cfg(32'h1b);
        chk("m27 a7", {ai[7], o1[7]}, da[7][31:16]);
        chk("m27 b6", {aq[6], o2[6]}, db[6][31:16]);
        cfg(32'h25);
        chk("m37 a1", {aq[0], o2[0]}, da[1][31:16]);
        chk("m37 b0", {bi, obi}, db[0][31:16]);
        cfg(32'h26);
        chk("m38 b0", {aq[0], o2[0]}, db[0][31:16]);
        chk("m38 lanes", 32'(LMT_LANES_TWO), act);
        cfg(32'h27);
        chk("m39 a0", {ai[0], o1[0], aq[0], o2[0]}, da[0]);
        cfg(32'h38);
        chk("m56 b0", {bi, obi, bq, obq}, db[0]);
        cfg(32'h1020);
        chk("fec", 32'h1, fec);
    endtask : t_words
    task t_clock;
        cfg(32'h622);
        chk("clk b1", LMT_CLK_WORD, db[1]);
        chk("clk lanes", 32'(LMT_LANES_FOUR), act);
        chk("clk a2", 32'h0, da[2]);
    endtask : t_clock
    task t_prbs;
        for (int p = 1; p < 6; p++)
        begin
            cfg(32'h20020 | (p << 8));
            chk("cfg off", 32'h0, drv);
            cfg(32'h20 | (p << 8));
            repeat (4) @(posedge hclk);
            ta <= 5'(TA[p-1]);
            tb <= 5'(TB[p-1]);
            chk_en <= 1'b1;
            repeat (40) @(posedge hclk);
            chk_en <= 1'b0;
        end
        #1;
        chk("prbs errors", 32'h0, errs);
        chk("prbs words", 32'h1, chks > 16'd100);
    endtask : t_prbs
    task t_shut;
        @(posedge hclk);
        pin <= 1'b1;
        repeat (6) @(posedge hclk);
        #1;
        chk("pin drive", 32'h0, drv);
        chk("pin a0", 32'h0, da[0]);
        chk("pin lanes", 32'h0, act);
        @(posedge hclk);
        pin <= 1'b0;
        repeat (5) @(posedge hclk);
        #1;
        chk("pin back", 32'h1, drv);
    endtask : t_shut
    initial
    begin
        {hresetn, hsel, hwrite, pin, chk_en, obi, haddr, hwdata, htrans, ta, tb} = '0;
        {o1, o2, bi, bq, obq} = {8'ha5, 8'h3c, 15'h2b6d, 15'h51e3, 1'b1};
        for (int i = 0; i < 8; i++)
        begin
            sa[i] = 12'(12'h123 * (i + 1));
            sb[i] = 12'(12'hfed - 12'h111 * i);
            ai[i] = 15'(15'h1234 + 15'h0f0f * i);
            aq[i] = 15'(15'h6a51 - 15'h0777 * i);
        end
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_pack12;
        t_pack8;
        t_words;
        t_clock;
        t_prbs;
        t_shut;
        summarize;
    end
    initial
    begin
        repeat (5000) @(posedge hclk);
        fail_count++;
        summarize;
    end
endmodule : tb_top
